// file: logic/wbaf_bank_flags.sv
// I/O register bank for the first-bank channel delay, sign, position and buffer flags.
// Summary of operation
// - Delay status reads one bit per channel: address halted, envelope still running.
// - Delay bit clears when envelope moves from delay buffer to non-delay buffer.
// - Hardware sets delay bit only when envelope starts a delay-mode buffer.
// - Delay and sign registers: write one sets the bit, zero leaves it.
// - Sign bit zero means at or above loop begin, one means at or below.
// - Software may preload sign bits; the address engine then keeps them current.
// - Position flag reads zero before half end offset, one from half to end.
// - End offset spans loop begin to loop end; flag drives sample double buffering.
// - Buffer select reads zero for first parameter buffer, one for the second.
// - Writing one inverts the buffer flag and forces the envelope engine over.
// - Channel stop clears its sign, position and buffer select bits.
// - Channel stop also clears its delay status bit.
// - Channel stops on a stop command or other causes, halting both engines.
`default_nettype none
module wbaf_bank_flags (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [wbaf_pkg::ADDR_W-1:0] ioAddr,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [wbaf_pkg::NUM_BYTES-1:0] ioByteEn,
  input wire logic [wbaf_pkg::DATA_W-1:0] ioWData,
  output logic [wbaf_pkg::DATA_W-1:0] ioRData,
  input wire logic [wbaf_pkg::NUM_CHAN-1:0] chanRunning,
  input wire logic [wbaf_pkg::NUM_CHAN-1:0] envDelayEnter,
  input wire logic [wbaf_pkg::NUM_CHAN-1:0] envDelayLeave,
  input wire logic [wbaf_pkg::NUM_CHAN-1:0] envBufToggle,
  input wire logic engValid,
  input wire logic [wbaf_pkg::CHAN_W-1:0] engChan,
  input wire logic engSign,
  input wire logic [wbaf_pkg::OFFS_W-1:0] engCurOffset,
  input wire logic [wbaf_pkg::OFFS_W-1:0] engEndOffset,
  output logic [wbaf_pkg::NUM_CHAN-1:0] envBufSelect,
  output logic [wbaf_pkg::NUM_CHAN-1:0] envBufForce
);
  wbaf_pkg::wbaf_bank_t q;
  wbaf_pkg::wbaf_bank_t d;
  logic [wbaf_pkg::DATA_W-1:0] wrMask;
  logic [wbaf_pkg::NUM_CHAN-1:0] delayVec;
  logic [wbaf_pkg::NUM_CHAN-1:0] signVec;
  logic [wbaf_pkg::NUM_CHAN-1:0] posVec;
  logic [wbaf_pkg::NUM_CHAN-1:0] bufVec;
  logic [wbaf_pkg::NUM_CHAN-1:0] forceVec;
  logic wrDelay;
  logic wrSign;
  logic wrBufSel;
  logic engPastHalf;

  // The position register has no write strobe at all, so writes to it fall away.
  assign wrDelay = ioWr && (ioAddr == wbaf_pkg::ADDR_DELAY);
  assign wrSign = ioWr && (ioAddr == wbaf_pkg::ADDR_SIGN);
  assign wrBufSel = ioWr && (ioAddr == wbaf_pkg::ADDR_BUFSEL);

  // One shared compare serves all channels because the address engine is time-shared.
  // The half point is measured from loop begin, so both offsets are loop-relative.
  assign engPastHalf = engCurOffset >= (engEndOffset >> 1);

  genvar n;
  generate
    for (n = 0; n < wbaf_pkg::NUM_CHAN; n++) begin : g_chan
      assign wrMask[n] = ioWData[n] & ioByteEn[n / wbaf_pkg::BYTE_W];
      wbaf_chan_cell u_cell (
        .clk(clk),
        .rst_n(rst_n),
        .running(chanRunning[n]),
        .swSetDelay(wrDelay & wrMask[n]),
        .swSetSign(wrSign & wrMask[n]),
        .swToggleBuf(wrBufSel & wrMask[n]),
        .delayEnter(envDelayEnter[n]),
        .delayLeave(envDelayLeave[n]),
        .hwBufToggle(envBufToggle[n]),
        .engHit(engValid && (int'(engChan) == n)),
        .engSign(engSign),
        .engPastHalf(engPastHalf),
        .delay(delayVec[n]),
        .sign(signVec[n]),
        .pos(posVec[n]),
        .bufSel(bufVec[n]),
        .bufForce(forceVec[n])
      );
    end
  endgenerate

  always_comb begin
    d = q;
    if (ioRd) begin
      case (ioAddr)
        wbaf_pkg::ADDR_DELAY: d.rdData = delayVec;
        wbaf_pkg::ADDR_SIGN: d.rdData = signVec;
        wbaf_pkg::ADDR_POS: d.rdData = posVec;
        wbaf_pkg::ADDR_BUFSEL: d.rdData = bufVec;
        default: d.rdData = wbaf_pkg::UNMAPPED_WORD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q.rdData <= wbaf_pkg::RESET_WORD;
    end else begin
      q <= d;
    end
  end

  assign ioRData = q.rdData;
  assign envBufSelect = bufVec;
  assign envBufForce = forceVec;

  chk_read_delay_word: assert property (@(posedge clk) disable iff (!rst_n)
    (ioRd && ioAddr == wbaf_pkg::ADDR_DELAY) |=> (ioRData == $past(delayVec)))
    else $error("delay status read returned wrong word");
  chk_read_pos_word: assert property (@(posedge clk) disable iff (!rst_n)
    (ioRd && ioAddr == wbaf_pkg::ADDR_POS) |=> (ioRData == $past(posVec)))
    else $error("position flag read returned wrong word");
  chk_pos_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (ioWr && ioAddr == wbaf_pkg::ADDR_POS && !engValid && $stable(chanRunning))
      |=> $stable(posVec))
    else $error("position flag changed by a register write");

  // Bank-wide views of the channel rules. A falling running bit is a stop that clears
  // everything, so checks that expect a flag to survive only look at steady running bits.
  chk_read_sign_word: assert property (@(posedge clk) disable iff (!rst_n)
    (ioRd && ioAddr == wbaf_pkg::ADDR_SIGN) |=> (ioRData == $past(signVec)))
    else $error("sign read returned wrong word");
  chk_read_buf_word: assert property (@(posedge clk) disable iff (!rst_n)
    (ioRd && ioAddr == wbaf_pkg::ADDR_BUFSEL) |=> (ioRData == $past(bufVec)))
    else $error("buffer select read returned wrong word");
  chk_read_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !ioRd |=> $stable(ioRData))
    else $error("read data changed without a read");
  chk_read_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (ioRd && ioAddr != wbaf_pkg::ADDR_DELAY && ioAddr != wbaf_pkg::ADDR_SIGN
      && ioAddr != wbaf_pkg::ADDR_POS && ioAddr != wbaf_pkg::ADDR_BUFSEL)
      |=> (ioRData == wbaf_pkg::UNMAPPED_WORD))
    else $error("unmapped read returned nonzero data");

  chk_delay_write_set: assert property (@(posedge clk) disable iff (!rst_n)
    (wrDelay && $stable(chanRunning)) |=> (($past(wrMask) & ~delayVec) == '0))
    else $error("delay write of one did not set the bit");
  chk_delay_write_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (wrDelay && envDelayLeave == '0 && $stable(chanRunning))
      |=> (($past(delayVec) & ~delayVec) == '0))
    else $error("delay write cleared a bit");
  chk_delay_enter_set: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(chanRunning) |=> (($past(envDelayEnter) & ~delayVec) == '0))
    else $error("delay bit not set on entering a delay buffer");
  chk_delay_leave_bank: assert property (@(posedge clk) disable iff (!rst_n)
    (!wrDelay && $stable(chanRunning))
      |=> (($past(envDelayLeave) & ~$past(envDelayEnter) & delayVec) == '0))
    else $error("delay bit kept after leaving the delay buffer");
  chk_delay_no_cause: assert property (@(posedge clk) disable iff (!rst_n)
    (!wrDelay && envDelayEnter == '0 && envDelayLeave == '0 && $stable(chanRunning))
      |=> $stable(delayVec))
    else $error("delay bits changed without a cause");

  chk_sign_write_bank: assert property (@(posedge clk) disable iff (!rst_n)
    (wrSign && $stable(chanRunning)) |=> (($past(wrMask) & ~signVec) == '0))
    else $error("sign write of one did not set the bit");
  chk_sign_write_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (wrSign && !engValid && $stable(chanRunning))
      |=> (($past(signVec) & ~signVec) == '0))
    else $error("sign write cleared a bit");
  chk_sign_engine_value: assert property (@(posedge clk) disable iff (!rst_n)
    (engValid && !wrSign && $stable(chanRunning))
      |=> (signVec[$past(engChan)] == $past(engSign)))
    else $error("sign bit disagrees with the address engine update");
  chk_sign_no_cause: assert property (@(posedge clk) disable iff (!rst_n)
    (!engValid && !wrSign && $stable(chanRunning)) |=> $stable(signVec))
    else $error("sign bits changed without a cause");
  chk_pos_no_cause: assert property (@(posedge clk) disable iff (!rst_n)
    (!engValid && $stable(chanRunning)) |=> $stable(posVec))
    else $error("position flags changed without an engine update");

  chk_buf_engine_bank: assert property (@(posedge clk) disable iff (!rst_n)
    (!wrBufSel && $stable(chanRunning))
      |=> ((bufVec ^ $past(bufVec)) == $past(envBufToggle)))
    else $error("buffer select does not follow the engine toggles");
  chk_buf_write_bank: assert property (@(posedge clk) disable iff (!rst_n)
    (wrBufSel && envBufToggle == '0 && $stable(chanRunning))
      |=> ((bufVec ^ $past(bufVec)) == $past(wrMask)))
    else $error("buffer select does not follow the written ones");
  chk_force_idle_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !wrBufSel |=> (envBufForce == '0))
    else $error("buffer force raised without a write");
  chk_force_matches_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wrBufSel && $stable(chanRunning)) |=> (envBufForce == $past(wrMask)))
    else $error("buffer force differs from the written ones");

  // A stop is taken on the edge that samples the running bit low, and only if the edge before it was not in reset.
  chk_stop_clear_bank: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> (((delayVec | signVec | posVec | bufVec)
      & $past(chanRunning, 2) & ~$past(chanRunning)) == '0))
    else $error("flags of a stopped channel not cleared");
endmodule
`default_nettype wire

// file: logic/wbaf_pkg.sv
// Shared constants and state types for the first-bank channel flag registers.
`default_nettype none
package wbaf_pkg;
  localparam int NUM_CHAN = 32;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CHAN_W = 5;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 4;
  // Sample offset width is not fixed by the register map; 16 bits is a plain default.
  localparam int OFFS_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_DELAY = 8'h88;
  localparam logic [ADDR_W-1:0] ADDR_SIGN = 8'h8C;
  localparam logic [ADDR_W-1:0] ADDR_POS = 8'h90;
  localparam logic [ADDR_W-1:0] ADDR_BUFSEL = 8'h94;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_WORD = 32'h0000_0000;

  typedef struct packed {
    logic delay;
    logic sign;
    logic pos;
    logic bufSel;
    logic bufForce;
    logic runPrev;
  } wbaf_cell_t;

  localparam wbaf_cell_t CELL_RESET = '{default: 1'b0};

  typedef struct packed {
    logic [DATA_W-1:0] rdData;
  } wbaf_bank_t;
endpackage
`default_nettype wire

// file: logic/wbaf_chan_cell.sv
// One channel's delay, offset sign, half-loop position and envelope buffer flags.
`default_nettype none
module wbaf_chan_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic running,
  input wire logic swSetDelay,
  input wire logic swSetSign,
  input wire logic swToggleBuf,
  input wire logic delayEnter,
  input wire logic delayLeave,
  input wire logic hwBufToggle,
  input wire logic engHit,
  input wire logic engSign,
  input wire logic engPastHalf,
  output logic delay,
  output logic sign,
  output logic pos,
  output logic bufSel,
  output logic bufForce
);
  wbaf_pkg::wbaf_cell_t q;
  wbaf_pkg::wbaf_cell_t d;
  logic stopNow;

  // A channel enters the stopped state on the falling edge of its running status.
  assign stopNow = q.runPrev & ~running;

  always_comb begin
    d = q;
    d.runPrev = running;
    if (delayLeave) begin
      d.delay = 1'b0;
    end
    // Entering a delay buffer or a software set wins over a leave in the same cycle.
    if (delayEnter | swSetDelay) begin
      d.delay = 1'b1;
    end
    if (engHit) begin
      d.sign = engSign;
      d.pos = engPastHalf;
    end
    if (swSetSign) begin
      d.sign = 1'b1;
    end
    // Two toggles in one cycle cancel, so software and engine never lose each other's step.
    if (swToggleBuf ^ hwBufToggle) begin
      d.bufSel = ~q.bufSel;
    end
    d.bufForce = swToggleBuf;
    if (stopNow) begin
      d.sign = 1'b0;
      d.pos = 1'b0;
      d.bufSel = 1'b0;
      d.bufForce = 1'b0;
      d.delay = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= wbaf_pkg::CELL_RESET;
    end else begin
      q <= d;
    end
  end

  assign delay = q.delay;
  assign sign = q.sign;
  assign pos = q.pos;
  assign bufSel = q.bufSel;
  assign bufForce = q.bufForce;

  chk_stop_clear_flags: assert property (@(posedge clk) disable iff (!rst_n)
    stopNow |=> (!sign && !pos && !bufSel))
    else $error("flags not cleared on channel stop");
  chk_stop_clear_delay: assert property (@(posedge clk) disable iff (!rst_n)
    stopNow |=> !delay)
    else $error("delay flag not cleared on channel stop");
  chk_delay_set_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(delay) |-> $past(delayEnter || swSetDelay))
    else $error("delay flag set without a cause");
  chk_delay_leave_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (delayLeave && !delayEnter && !swSetDelay) |=> !delay)
    else $error("delay flag kept after leaving delay buffer");
  chk_sign_write_set: assert property (@(posedge clk) disable iff (!rst_n)
    (swSetSign && !stopNow) ##1 1'b1 |-> sign)
    else $error("sign bit not set by a write of one");
  chk_pos_engine_update: assert property (@(posedge clk) disable iff (!rst_n)
    (engHit && !stopNow) |=> (pos == $past(engPastHalf)))
    else $error("position flag disagrees with half-loop compare");
  chk_buf_toggle_step: assert property (@(posedge clk) disable iff (!rst_n)
    ((swToggleBuf ^ hwBufToggle) && !stopNow) |=> (bufSel != $past(bufSel)))
    else $error("buffer select did not toggle");
  chk_buf_hold_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (!swToggleBuf && !hwBufToggle && !stopNow) |=> $stable(bufSel))
    else $error("buffer select changed without a toggle");
  chk_buf_force_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    (swToggleBuf && !stopNow) |=> bufForce ##1 (bufForce == $past(swToggleBuf)))
    else $error("buffer force pulse not issued for a software toggle");
endmodule
`default_nettype wire

// file: verif/wbaf_testbench.sv
// Self-checking bench for the first-bank channel flag register bank.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, ioWr, ioRd, engValid, engSign;
  logic [7:0] ioAddr;
  logic [3:0] ioByteEn;
  logic [4:0] engChan;
  logic [15:0] engCurOffset, engEndOffset;
  logic [31:0] ioWData, ioRData, chanRunning, envDelayEnter, envDelayLeave, envBufToggle;
  logic [31:0] envBufSelect, envBufForce;
  int errors = 0;
  int checks = 0;
  wbaf_bank_flags dut (.clk(clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioByteEn(ioByteEn), .ioWData(ioWData), .ioRData(ioRData), .chanRunning(chanRunning),
    .envDelayEnter(envDelayEnter), .envDelayLeave(envDelayLeave), .envBufToggle(envBufToggle),
    .engValid(engValid), .engChan(engChan), .engSign(engSign), .engCurOffset(engCurOffset),
    .engEndOffset(engEndOffset), .envBufSelect(envBufSelect), .envBufForce(envBufForce));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic final_report();
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge clk);
    ioWr = 1'b1;
    ioAddr = a;
    ioWData = d;
    ioByteEn = be;
    @(negedge clk);
    ioWr = 1'b0;
  endtask
  // Read data lands on the edge that takes the strobe, so it is settled one falling edge later.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    ioRd = 1'b1;
    ioAddr = a;
    @(negedge clk);
    ioRd = 1'b0;
    chk(ioRData, exp);
  endtask
  // Kind 0 enters delay mode, 1 leaves it, 2 toggles the envelope buffer.
  task automatic epulse(input int kind, input logic [31:0] m);
    @(negedge clk);
    if (kind == 0) envDelayEnter = m;
    if (kind == 1) envDelayLeave = m;
    if (kind == 2) envBufToggle = m;
    @(negedge clk);
    envDelayEnter = '0;
    envDelayLeave = '0;
    envBufToggle = '0;
  endtask
  task automatic eng(input logic [4:0] ch, input logic s, input logic [15:0] cur);
    @(negedge clk);
    engValid = 1'b1;
    engChan = ch;
    engSign = s;
    engCurOffset = cur;
    engEndOffset = 16'h0064;
    @(negedge clk);
    engValid = 1'b0;
  endtask
  initial begin
    #(2000 * 100);
    errors++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    {ioWr, ioRd, engValid, engSign} = '0;
    ioAddr = '0;
    ioByteEn = '0;
    engChan = '0;
    engCurOffset = '0;
    engEndOffset = '0;
    ioWData = '0;
    chanRunning = '1;
    {envDelayEnter, envDelayLeave, envBufToggle} = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 5; i++) rdchk(8'h88 + 8'(4 * i), 32'h0000_0000);
    wr(8'h88, 32'h0000_0005, 4'hF);
    rdchk(8'h88, 32'h0000_0005);
    wr(8'h88, 32'h0000_0000, 4'hF);
    wr(8'h88, 32'h0000_0100, 4'h1);
    rdchk(8'h88, 32'h0000_0005);
    wr(8'h88, 32'h0000_0100, 4'h2);
    epulse(0, 32'h0000_0002);
    rdchk(8'h88, 32'h0000_0107);
    epulse(1, 32'h0000_0003);
    rdchk(8'h88, 32'h0000_0104);
    wr(8'h8C, 32'h0000_0008, 4'hF);
    rdchk(8'h8C, 32'h0000_0008);
    eng(5'h03, 1'b0, 16'h000A);
    rdchk(8'h8C, 32'h0000_0000);
    eng(5'h03, 1'b1, 16'h000A);
    rdchk(8'h8C, 32'h0000_0008);
    eng(5'h02, 1'b0, 16'h0032);
    rdchk(8'h90, 32'h0000_0004);
    eng(5'h02, 1'b0, 16'h0031);
    rdchk(8'h90, 32'h0000_0000);
    eng(5'h02, 1'b0, 16'h0064);
    wr(8'h90, 32'hFFFF_FFFF, 4'hF);
    rdchk(8'h90, 32'h0000_0004);
    wr(8'h94, 32'h0000_0001, 4'hF);
    chk(envBufForce, 32'h0000_0001);
    chk(envBufSelect, 32'h0000_0001);
    @(negedge clk);
    chk(envBufForce, 32'h0000_0000);
    epulse(2, 32'h0000_0010);
    rdchk(8'h94, 32'h0000_0011);
    wr(8'h94, 32'h0000_0001, 4'hF);
    rdchk(8'h94, 32'h0000_0010);
    wr(8'h88, 32'h0000_0020, 4'hF);
    wr(8'h8C, 32'h0000_0020, 4'hF);
    wr(8'h94, 32'h0000_0020, 4'hF);
    eng(5'h05, 1'b1, 16'h003C);
    rdchk(8'h90, 32'h0000_0024);
    @(negedge clk);
    chanRunning[5] = 1'b0;
    @(negedge clk);
    rdchk(8'h88, 32'h0000_0104);
    rdchk(8'h8C, 32'h0000_0008);
    rdchk(8'h90, 32'h0000_0004);
    rdchk(8'h94, 32'h0000_0010);
    chk(envBufSelect, 32'h0000_0010);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) rdchk(8'h88 + 8'(4 * i), 32'h0000_0000);
    chk(envBufSelect, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
